// *** adcpc_conversion_control.sv ***
`timescale 1ns/1ns
`default_nettype none
// Function
// R1: result is 14-bit two's complement code
// R2: start low with select low begins conversion
// R3: starts ignored while conversion runs
// R4: busy low throughout conversion
// R5: conversion timed by internal counter
// R6: host waits acquisition time after conversion
// R7: one conversion per 1.25 us cycle
// R8: select and read low: outputs always driven
// R9: only select low: outputs three-state until read
// R10: slow memory: previous result shown during conversion
// R11: slow memory: new result appears as busy rises
// R12: rom mode: strobe reads previous, starts next
// R13: shutdown while power-down input low
// R14: select picks nap low, sleep high
// R15: nap wake needs 400 ns
// R16: sleep wake needs reference settling
// R17: host keeps bus quiet during conversion
// R18: drivers enabled only while select and read low
// R19: result held until next conversion completes
module adcpc_conversion_control #(
	parameter int SLEEP_WAKE_CYC = adcpc_pkg::SLEEP_WAKE_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        conversion_start_n,
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic        power_down_n,
	input  wire logic [13:0] sample,
	output logic      [13:0] data_out,
	output logic      [13:0] data_oe,
	output logic             busy_n,
	output logic             sample_hold,
	output logic             ref_power,
	output logic             core_power,
	output logic             ready
);
	adcpc_pkg::adcpc_state_e  state;
	adcpc_pkg::adcpc_state_e  next_state;
	adcpc_pkg::adcpc_sdmode_e sdmode;
	adcpc_pkg::adcpc_sdmode_e next_sdmode;
	logic [19:0] cnt;
	logic [19:0] next_cnt;
	logic [13:0] result;
	logic [13:0] next_result;
	logic [13:0] code;
	logic        start_prev;
	logic        start_fall;
	logic        next_busy_n;
	logic [13:0] next_oe;
	logic        next_ready;

	adcpc_quantizer u_quant (
		.sample (sample),
		.code   (code)
	);

	// ==============================
	// start edge detect; inputs are synchronous to clk
	assign start_fall = start_prev & ~conversion_start_n;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			start_prev <= 1'b1;
		end else begin
			start_prev <= conversion_start_n;
		end
	end

	// ==============================
	// converter sequencer
	always_comb begin
		next_state  = state;
		next_cnt    = cnt;
		next_result = result;
		next_sdmode = sdmode;
		case (state)
			adcpc_pkg::ADCPC_IDLE: begin
				// acquisition spacing is left to the host, so a start is taken at once [R6] [R7]
				if (!power_down_n) begin // [R13]
					next_state  = adcpc_pkg::ADCPC_DOWN;
					next_sdmode = cs_n ? adcpc_pkg::ADCPC_SLEEP : adcpc_pkg::ADCPC_NAP; // [R14]
				end else if (start_fall && !cs_n) begin // [R2]
					next_state = adcpc_pkg::ADCPC_CONV;
					next_cnt   = adcpc_pkg::CNT_RST;
				end
			end
			adcpc_pkg::ADCPC_CONV: begin
				// start edges are not looked at here, so a running conversion cannot restart
				if (cnt == 20'(adcpc_pkg::CONV_CYC - 1)) begin // [R3] [R5]
					next_state  = adcpc_pkg::ADCPC_IDLE;
					next_result = code; // [R1] [R11] [R19]
				end else begin
					next_cnt = 20'(cnt + 20'h00001);
				end
			end
			adcpc_pkg::ADCPC_DOWN: begin
				if (power_down_n) begin // [R13]
					next_state = adcpc_pkg::ADCPC_WAKE;
					next_cnt   = adcpc_pkg::CNT_RST;
				end
			end
			adcpc_pkg::ADCPC_WAKE: begin
				// wake time depends on flavour; a start during wake is ignored
				if (!power_down_n) begin
					next_state = adcpc_pkg::ADCPC_DOWN;
				end else if ((sdmode == adcpc_pkg::ADCPC_NAP &&
					cnt >= 20'(adcpc_pkg::NAP_WAKE_CYC - 1)) ||
					(sdmode == adcpc_pkg::ADCPC_SLEEP &&
					cnt >= 20'(SLEEP_WAKE_CYC - 1))) begin // [R15] [R16]
					next_state = adcpc_pkg::ADCPC_IDLE;
				end else begin
					next_cnt = 20'(cnt + 20'h00001);
				end
			end
			default: begin
				next_state = adcpc_pkg::ADCPC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state  <= adcpc_pkg::ADCPC_IDLE;
			cnt    <= adcpc_pkg::CNT_RST;
			result <= adcpc_pkg::RESULT_RST;
			sdmode <= adcpc_pkg::ADCPC_NAP;
		end else begin
			state  <= next_state;
			cnt    <= next_cnt;
			result <= next_result;
			sdmode <= next_sdmode;
		end
	end

	// ==============================
	// registered pin outputs; data_out follows result, so it changes with busy rising
	always_comb begin
		next_busy_n = (next_state != adcpc_pkg::ADCPC_CONV); // [R4]
		// drive only for a read; tying both low keeps them always on (modes 1a/1b)
		next_oe     = (!cs_n && !rd_n) ? 14'h3fff : 14'h0000; // [R8] [R9] [R18]
		next_ready  = (next_state == adcpc_pkg::ADCPC_IDLE);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_n      <= 1'b1;
			data_oe     <= 14'h0000;
			data_out    <= adcpc_pkg::RESULT_RST;
			sample_hold <= 1'b0;
			ref_power   <= 1'b1;
			core_power  <= 1'b1;
			ready       <= 1'b1;
		end else begin
			busy_n      <= next_busy_n;
			data_oe     <= next_oe;
			data_out    <= next_result; // [R10] [R12] [R19]
			sample_hold <= (next_state == adcpc_pkg::ADCPC_CONV);
			// nap keeps reference up; sleep drops it too
			ref_power   <= !(next_state == adcpc_pkg::ADCPC_DOWN &&
				next_sdmode == adcpc_pkg::ADCPC_SLEEP); // [R14]
			core_power  <= (next_state != adcpc_pkg::ADCPC_DOWN); // [R13]
			ready       <= next_ready;
		end
	end

	// ==============================
	// assertions
	a_busy_width: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
		$fell(busy_n) |-> (!busy_n) [*8] ##0 (!busy_n) [*8])
		else $error("busy too short");
	a_busy_end: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
		$fell(busy_n) |-> ##[1:57] busy_n)
		else $error("conversion overran");
	a_start_conv: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
		(state == adcpc_pkg::ADCPC_IDLE && power_down_n && start_fall && !cs_n) |=> !busy_n)
		else $error("start not taken");
	a_no_restart: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
		(state == adcpc_pkg::ADCPC_CONV && start_fall) |=> $stable(cnt) || cnt == $past(cnt) + 20'h00001
		|| state == adcpc_pkg::ADCPC_IDLE)
		else $error("conversion restarted");
	a_oe_gate: assert property (@(posedge clk) disable iff (!rst_b) // [R18]
		(cs_n || rd_n) |=> data_oe == 14'h0000)
		else $error("driving without read");
	a_oe_read: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
		(!cs_n && !rd_n) |=> data_oe == 14'h3fff)
		else $error("not driving on read");
	a_data_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
		(busy_n && $past(busy_n)) |-> $stable(data_out))
		else $error("result changed while idle");
	a_new_data: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
		$rose(busy_n) |-> data_out == $past(code))
		else $error("new result missing at busy rise");
	a_shutdown: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
		(state == adcpc_pkg::ADCPC_IDLE && !power_down_n) |=> !core_power)
		else $error("shutdown not entered");
	a_sleep_ref: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
		(state == adcpc_pkg::ADCPC_IDLE && !power_down_n) |=> (ref_power == !$past(cs_n)))
		else $error("wrong shutdown flavour");
	a_nap_wake: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
		(state == adcpc_pkg::ADCPC_DOWN && power_down_n && sdmode == adcpc_pkg::ADCPC_NAP)
		|=> (!ready) [*8] ##1 (!ready || !power_down_n) [*8])
		else $error("nap wake too early");

	c_conv: cover property (@(posedge clk) disable iff (!rst_b) $rose(busy_n));
	c_read: cover property (@(posedge clk) disable iff (!rst_b) !busy_n && !rd_n && !cs_n);
	c_nap: cover property (@(posedge clk) disable iff (!rst_b) $rose(core_power) && ref_power);
	c_sleep: cover property (@(posedge clk) disable iff (!rst_b) $fell(ref_power));
endmodule
`default_nettype wire

// *** adcpc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==============================
// host side: latches the result when busy returns high
module adcpc_host_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        busy_n,
	input  wire logic [13:0] data_out,
	output logic      [13:0] latched
);
	logic busy_d;
	// data_out updates on the edge busy rises, so take it one edge later
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_d  <= 1'b1;
			latched <= 14'h0000;
		end else begin
			busy_d <= busy_n;
			if (busy_n && !busy_d) begin
				latched <= data_out;
			end
		end
	end
endmodule
`default_nettype wire

// *** adcpc_pkg.sv ***
package adcpc_pkg;
	// ==============================
	// data format
	localparam int          DATA_W      = 14;
	localparam int          CODE_STEPS  = 16384;
	localparam logic [13:0] RESULT_RST  = 14'h0000;
	// ==============================
	// timing, figures in ns except the sleep wake time in ms, cycle counts derived from the 50 MHz clock
	localparam int CLK_PERIOD_NS  = 20;
	localparam int CONV_TYP_NS    = 950;
	localparam int CONV_MAX_NS    = 1150;
	localparam int ACQ_NS         = 300;
	localparam int THRU_NS        = 1250;
	localparam int NAP_WAKE_NS    = 400;
	localparam int SLEEP_WAKE_MS  = 10;
	// longest times round down, least times round up
	localparam int CONV_CYC       = CONV_TYP_NS / CLK_PERIOD_NS;
	localparam int CONV_MAX_CYC   = CONV_MAX_NS / CLK_PERIOD_NS;
	localparam int ACQ_CYC        = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int THRU_CYC       = (THRU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NAP_WAKE_CYC   = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CNT_W          = 20;
	localparam logic [19:0] CNT_RST = 20'h00000;
	// ==============================
	// converter state
	typedef enum logic [1:0] {
		ADCPC_IDLE = 2'b00,
		ADCPC_CONV = 2'b01,
		ADCPC_DOWN = 2'b10,
		ADCPC_WAKE = 2'b11
	} adcpc_state_e;
	typedef enum logic {
		ADCPC_NAP   = 1'b0,
		ADCPC_SLEEP = 1'b1
	} adcpc_sdmode_e;
endpackage

// *** adcpc_quantizer.sv ***
`timescale 1ns/1ns
`default_nettype none
// maps an offset-binary sample of the analog core to the two's complement result
module adcpc_quantizer (
	input  wire logic [13:0] sample,
	output logic      [13:0] code
);
	// ==============================
	// mid-tread rounding is done by the analog core; here only the sign bit flips
	assign code = {~sample[13], sample[12:0]}; // [R1]
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk, rst_b, conversion_start_n, cs_n, rd_n, power_down_n;
	logic [13:0] sample, data_out, data_oe, latched;
	logic busy_n, sample_hold, ref_power, core_power, ready;
	int err_total, checked, cyc;
	adcpc_conversion_control #(.SLEEP_WAKE_CYC(50)) dut (.clk(clk), .rst_b(rst_b),
		.conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n),
		.power_down_n(power_down_n), .sample(sample), .data_out(data_out),
		.data_oe(data_oe), .busy_n(busy_n), .sample_hold(sample_hold),
		.ref_power(ref_power), .core_power(core_power), .ready(ready));
	adcpc_host_model host (.clk(clk), .rst_b(rst_b), .busy_n(busy_n),
		.data_out(data_out), .latched(latched));
	// ==============================
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	// ==============================
	// one conversion; a second start falls within its first ten cycles and must be ignored
	task automatic conv(input logic [13:0] s, input logic [13:0] prev, input bit slow);
		int n;
		n = 0;
		sample = s;
		cs_n = 1'b0;
		conversion_start_n = 1'b0;
		if (slow) rd_n = 1'b0;
		for (int i = 0; i < 60; i++) begin
			@(negedge clk);
			if (busy_n === 1'b0) n++;
			if (i == 2 && slow) chk("prev", data_out, prev);
			if (i == 2) chk("oe_conv", data_oe, slow ? 14'h3fff : 14'h0000);
			if (i == 2) chk("hold_on", {13'h0000, sample_hold}, 14'h0001);
			if (i == 2) chk("busy_ready", {13'h0000, ready}, 14'h0000);
			if (i == 5) conversion_start_n = 1'b1;
			if (i == 6) conversion_start_n = 1'b0;
		end
		chk("busy_len", 14'(n), 14'h002f);
		chk("code", data_out, {~s[13], s[12:0]});
		chk("latched", latched, {~s[13], s[12:0]});
		chk("hold_off", {13'h0000, sample_hold}, 14'h0000);
		conversion_start_n = 1'b1;
		rd_n = 1'b1;
		wait_n(20); // host acquisition spacing
	endtask
	task automatic read_gate(input logic [13:0] exp);
		rd_n = 1'b1;
		wait_n(2);
		chk("oe_idle", data_oe, 14'h0000);
		rd_n = 1'b0;
		wait_n(2);
		chk("oe_read", data_oe, 14'h3fff);
		chk("reread", data_out, exp);
		cs_n = 1'b1;
		wait_n(2);
		chk("oe_desel", data_oe, 14'h0000);
		rd_n = 1'b1;
		conversion_start_n = 1'b0;
		wait_n(3);
		chk("no_sel", {13'h0000, busy_n}, 14'h0001);
		conversion_start_n = 1'b1;
		wait_n(2);
	endtask
	task automatic shut(input logic sel, input int bound);
		int n;
		n = 0;
		cs_n = sel;
		power_down_n = 1'b0;
		wait_n(2);
		chk("core_off", {13'h0000, core_power}, 14'h0000);
		chk("ref", {13'h0000, ref_power}, {13'h0000, ~sel});
		power_down_n = 1'b1;
		wait_n(2);
		chk("waking", {13'h0000, ready}, 14'h0000);
		while (ready !== 1'b1 && n < bound) begin
			n++;
			@(negedge clk);
		end
		chk("awake", {13'h0000, ready & core_power}, 14'h0001);
		cs_n = 1'b1;
	endtask
	// ==============================
	// main sequence
	initial begin
		err_total = 0;
		checked = 0;
		cyc = 0;
		rst_b = 1'b0;
		conversion_start_n = 1'b1;
		cs_n = 1'b1;
		rd_n = 1'b1;
		power_down_n = 1'b1;
		sample = 14'h0000;
		wait_n(12);
		rst_b = 1'b1;
		wait_n(2);
		chk("rst_oe", data_oe, 14'h0000);
		chk("rst_busy", {13'h0000, busy_n}, 14'h0001);
		conv(14'h1234, 14'h0000, 1'b0);
		read_gate(14'h3234);
		conv(14'h2abc, 14'h3234, 1'b1);
		conv(14'h3fff, 14'h0abc, 1'b1);
		shut(1'b0, 25);
		shut(1'b1, 60);
		conv(14'h0000, 14'h1fff, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
